// *** verilog/tdc_pkg.sv ***
// package: register map, field widths and tick timing for the tick/day calendar
package tdc_pkg;

    // register byte offsets on the register bus
    localparam logic [3:0] TICK_OFS       = 4'h0;
    localparam logic [3:0] DAY_OFS        = 4'h4;
    localparam logic [3:0] CTRL_OFS       = 4'h8;

    // field widths and reset values
    localparam int          TICK_W        = 32;
    localparam int          DAY_W         = 16;
    localparam logic [31:0] TICK_RST      = 32'h0000_0000;
    localparam logic [15:0] DAY_RST       = 16'h0000;
    localparam int          CTRL_RUN_BIT  = 0;
    localparam logic        CTRL_RUN_RST  = 1'b1;

    // timing: device clock and tick rate
    localparam int          CLK_HZ        = 250_000_000;
    localparam int          TICK_HZ       = 512;
    localparam int          DIV_COUNT     = CLK_HZ / TICK_HZ;
    localparam logic [18:0] DIV_LAST      = 19'(DIV_COUNT - 1);
    localparam int          DAY_SECONDS   = 86_400;
    localparam logic [31:0] TICKS_PER_DAY = 32'(TICK_HZ * DAY_SECONDS);

    // bus response codes
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    // write request carrier
    typedef struct packed {
        logic [3:0]  addr;
        logic [31:0] data;
        logic [3:0]  strb;
    } tdc_wreq_t;

endpackage : tdc_pkg

// *** verilog/tdc_calendar.sv ***
// tick/day calendar counter with an AXI4-Lite register slave
// Contract
// - generate a 512 Hz tick from the 250 MHz system clock
// - 32-bit signed tick counter increments by one every tick; the code keeps it as an unsigned logic [31:0]
// - tick counter wraps to its start value after one day of ticks
// - 16-bit unsigned day counter increments on each tick counter wrap
// - day value zero means 1 January 1999
//
// The address map and the AXI4-Lite register port were left to the implementer.
module tdc_calendar
#(
    // divider end count; the default gives 512 Hz from 250 MHz, a smaller value shortens the tick period
    parameter logic [18:0] DIV_LAST = tdc_pkg::DIV_LAST
)
(
    // clock and reset
    input  wire logic        CLOCK,
    input  wire logic        RST,
    // write address channel
    input  wire logic [31:0] S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    // write data channel
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    // write response channel
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    // read address channel
    input  wire logic [31:0] S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    // read data channel
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY,
    // tick strobe, one cycle per 512 Hz tick
    output logic             TICK_PULSE
);

    logic [18:0]         div_reg;
    logic [31:0]         tick_counter_reg;
    logic [31:0]         tick_counter_next;
    logic [15:0]         day_counter_reg;
    logic [15:0]         day_counter_next;
    logic                run_reg;
    logic                tick_now;
    logic                aw_held_reg;
    logic                w_held_reg;
    tdc_pkg::tdc_wreq_t  wreq_reg;
    logic                wr_fire;
    logic                wr_hit_tick;
    logic                wr_hit_day;
    logic                wr_hit_ctrl;
    logic [31:0]         wmask;

    always_ff @(posedge CLOCK)
    begin
        if (RST || !run_reg || div_reg == DIV_LAST)
            div_reg <= 19'h0;
        else
            div_reg <= div_reg + 19'h1;
    end

    assign tick_now = run_reg && (div_reg == DIV_LAST);

    // tick strobe output
    always_ff @(posedge CLOCK)
    begin
        if (RST)
            TICK_PULSE <= 1'b0;
        else
            TICK_PULSE <= tick_now;
    end

    // write request capture, address and data in either order
    always_ff @(posedge CLOCK)
    begin
        if (RST)
        begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            wreq_reg    <= '0;
        end
        else
        begin
            if (S_AXI_AWVALID && S_AXI_AWREADY)
            begin
                aw_held_reg   <= 1'b1;
                wreq_reg.addr <= S_AXI_AWADDR[3:0];
            end
            if (S_AXI_WVALID && S_AXI_WREADY)
            begin
                w_held_reg    <= 1'b1;
                wreq_reg.data <= S_AXI_WDATA;
                wreq_reg.strb <= S_AXI_WSTRB;
            end
            if (wr_fire)
            begin
                aw_held_reg <= 1'b0;
                w_held_reg  <= 1'b0;
            end
        end
    end

    // a write commits once both halves are held and no response is pending
    assign wr_fire     = aw_held_reg && w_held_reg && !S_AXI_BVALID;
    assign wr_hit_tick = wr_fire && wreq_reg.addr == tdc_pkg::TICK_OFS;
    assign wr_hit_day  = wr_fire && wreq_reg.addr == tdc_pkg::DAY_OFS;
    assign wr_hit_ctrl = wr_fire && wreq_reg.addr == tdc_pkg::CTRL_OFS;

    // byte-lane mask from write strobes
    always_comb
    begin
        for (int i = 0; i < 4; i++)
            wmask[i*8 +: 8] = {8{wreq_reg.strb[i]}};
    end

    // handshake ready flags
    always_ff @(posedge CLOCK)
    begin
        if (RST)
        begin
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY  <= 1'b0;
        end
        else
        begin
            S_AXI_AWREADY <= !aw_held_reg && !(S_AXI_AWVALID && S_AXI_AWREADY) && !S_AXI_BVALID;
            S_AXI_WREADY  <= !w_held_reg && !(S_AXI_WVALID && S_AXI_WREADY) && !S_AXI_BVALID;
        end
    end

    // write response, unmapped offsets answer slave error
    always_ff @(posedge CLOCK)
    begin
        if (RST)
        begin
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP  <= tdc_pkg::RESP_OKAY;
        end
        else if (wr_fire)
        begin
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP  <= (wr_hit_tick || wr_hit_day || wr_hit_ctrl) ? tdc_pkg::RESP_OKAY
                                                                       : tdc_pkg::RESP_SLVERR;
        end
        else if (S_AXI_BREADY)
            S_AXI_BVALID <= 1'b0;
    end

    // counter next values; software write wins over a same-cycle tick
    always_comb
    begin
        tick_counter_next = tick_counter_reg;
        day_counter_next  = day_counter_reg;
        if (tick_now)
        begin
            tick_counter_next = tick_counter_reg + 32'h1;
            if (tick_counter_next == tdc_pkg::TICKS_PER_DAY)
            begin
                tick_counter_next = tdc_pkg::TICK_RST;
                day_counter_next  = day_counter_reg + 16'h1;
            end
        end
        if (wr_hit_tick)
            tick_counter_next = (tick_counter_reg & ~wmask) | (wreq_reg.data & wmask);
        if (wr_hit_day)
            day_counter_next = (day_counter_reg & ~wmask[15:0]) | (wreq_reg.data[15:0] & wmask[15:0]);
    end

    // day zero is the reference date after reset
    always_ff @(posedge CLOCK)
    begin
        if (RST)
        begin
            tick_counter_reg <= tdc_pkg::TICK_RST;
            day_counter_reg  <= tdc_pkg::DAY_RST;
        end
        else
        begin
            tick_counter_reg <= tick_counter_next;
            day_counter_reg  <= day_counter_next;
        end
    end

    // run control bit
    always_ff @(posedge CLOCK)
    begin
        if (RST)
            run_reg <= tdc_pkg::CTRL_RUN_RST;
        else if (wr_hit_ctrl && wreq_reg.strb[0])
            run_reg <= wreq_reg.data[tdc_pkg::CTRL_RUN_BIT];
    end

    // read channel: one-cycle address accept, data the next cycle
    always_ff @(posedge CLOCK)
    begin
        if (RST)
        begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b0;
            S_AXI_RDATA   <= 32'h0;
            S_AXI_RRESP   <= tdc_pkg::RESP_OKAY;
        end
        else
        begin
            S_AXI_ARREADY <= !S_AXI_RVALID && !(S_AXI_ARVALID && S_AXI_ARREADY);
            if (S_AXI_ARVALID && S_AXI_ARREADY)
            begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RRESP  <= tdc_pkg::RESP_OKAY;
                case (S_AXI_ARADDR[3:0])
                    tdc_pkg::TICK_OFS: S_AXI_RDATA <= tick_counter_reg;
                    tdc_pkg::DAY_OFS:  S_AXI_RDATA <= {16'h0, day_counter_reg};
                    tdc_pkg::CTRL_OFS: S_AXI_RDATA <= {31'h0, run_reg};
                    default:
                    begin
                        S_AXI_RDATA <= 32'h0;
                        S_AXI_RRESP <= tdc_pkg::RESP_SLVERR;
                    end
                endcase
            end
            else if (S_AXI_RREADY)
                S_AXI_RVALID <= 1'b0;
        end
    end

endmodule // tdc_calendar

// *** dv/tdc_calendar_monitor.sv ***
// checker: bus handshake and tick spacing for the calendar block
module tdc_calendar_monitor
#(
    // strobe spacing in clocks, follows the divider of the bound block
    parameter int DIV_COUNT = tdc_pkg::DIV_COUNT
)
(
    // clock and reset
    input wire logic        CLOCK,
    input wire logic        RST,
    // bus handshakes
    input wire logic        S_AXI_AWREADY,
    input wire logic        S_AXI_BVALID,
    input wire logic        S_AXI_BREADY,
    input wire logic        S_AXI_ARVALID,
    input wire logic        S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic        S_AXI_RVALID,
    input wire logic        S_AXI_RREADY,
    // tick strobe
    input wire logic        TICK_PULSE
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [19:0] gap_reg;
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);

    // cycles since reset or the last strobe
    always_ff @(posedge CLOCK)
    begin
        if (RST || TICK_PULSE)
            gap_reg <= 20'h0;
        else
            gap_reg <= gap_reg + 20'h1;
    end

    AST_R_ANSWER: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
        else $error("read answer late");
    AST_R_HOLD: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
        else $error("read data dropped");
    AST_R_BLOCK: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
        else $error("read taken while pending");
    AST_B_HOLD: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
        else $error("write answer dropped");
    AST_B_BLOCK: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY)
        else $error("write taken while pending");
    AST_TICK_ONE: assert property (TICK_PULSE |=> !TICK_PULSE)
        else $error("strobe too long");
    AST_TICK_MIN: assert property (TICK_PULSE |-> gap_reg >= DIV_COUNT - 1)
        else $error("tick too early");
    AST_TICK_MAX: assert property (gap_reg <= DIV_COUNT + 3)
        else $error("tick too late");

    // main scenarios
    cover property (TICK_PULSE);
    cover property (S_AXI_BVALID && S_AXI_BREADY);
    cover property (S_AXI_RVALID && S_AXI_RREADY);
endmodule // tdc_calendar_monitor

bind tdc_calendar tdc_calendar_monitor #(.DIV_COUNT(int'(DIV_LAST) + 1)) mon (.*);

// *** dv/tb_tdc_calendar.sv ***
// testbench: register access, reset and day wrap of the calendar block
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin bad_count++; $display("[FAIL] %0t got %h want %h", $time, a, e); end end
module tb_tdc_calendar;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        tdc_pkg::tdc_wreq_t req;
        logic [31:0]        exp;
        logic [1:0]         resp;
    } tdc_row_t;
    logic        CLOCK = 1'h0, RST = 1'h1, S_AXI_AWVALID = 1'h0, S_AXI_WVALID = 1'h0;
    logic        S_AXI_BREADY = 1'h0, S_AXI_ARVALID = 1'h0, S_AXI_RREADY = 1'h0;
    logic [31:0] S_AXI_AWADDR = 32'h0, S_AXI_WDATA = 32'h0, S_AXI_ARADDR = 32'h0, S_AXI_RDATA, d;
    logic [3:0]  S_AXI_WSTRB = 4'h0;
    logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, r;
    logic        S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, TICK_PULSE;
    int          bad_count = 0, n_tests = 0, cyc = 0;
    // write request, read-back value, response
    tdc_row_t    rows [5] = '{'{'{4'h0, 32'h1234_5678, 4'hf}, 32'h1234_5678, 2'h0},
        '{'{4'h0, 32'h0000_00aa, 4'h1}, 32'h1234_56aa, 2'h0},
        '{'{4'h4, 32'hdead_beef, 4'hf}, 32'h0000_beef, 2'h0},
        '{'{4'h8, 32'h0000_0001, 4'hf}, 32'h0000_0001, 2'h0},
        '{'{4'hc, 32'hffff_ffff, 4'hf}, 32'h0000_0000, 2'h2}};

    // short divider: one tick every 2000 clocks keeps the run brief
    tdc_calendar #(.DIV_LAST(19'h007cf)) dut (.*);

    always #2 CLOCK = ~CLOCK;

    // hang guard
    always @(posedge CLOCK)
    begin
        cyc++;
        if (cyc == 10000)
        begin
            bad_count++;
            close_out();
        end
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // bus write, each channel held until its own ready
    task automatic wr(input tdc_pkg::tdc_wreq_t q);
        logic aw;
        logic w;
        aw = 1'h1;
        w = 1'h1;
        @(posedge CLOCK);
        S_AXI_AWADDR <= {28'h0, q.addr};
        S_AXI_WDATA <= q.data;
        S_AXI_WSTRB <= q.strb;
        S_AXI_AWVALID <= 1'h1;
        S_AXI_WVALID <= 1'h1;
        S_AXI_BREADY <= 1'h1;
        while (aw || w)
        begin
            @(posedge CLOCK);
            if (S_AXI_AWREADY === 1'h1) aw = 1'h0;
            if (S_AXI_WREADY === 1'h1) w = 1'h0;
            S_AXI_AWVALID <= aw;
            S_AXI_WVALID <= w;
        end
        while (S_AXI_BVALID !== 1'h1) @(posedge CLOCK);
        r = S_AXI_BRESP;
        S_AXI_BREADY <= 1'h0;
    endtask

    // bus read of one word
    task automatic rd(input logic [3:0] a);
        @(posedge CLOCK);
        S_AXI_ARADDR <= {28'h0, a};
        S_AXI_ARVALID <= 1'h1;
        S_AXI_RREADY <= 1'h1;
        do @(posedge CLOCK); while (S_AXI_ARREADY !== 1'h1);
        S_AXI_ARVALID <= 1'h0;
        do @(posedge CLOCK); while (S_AXI_RVALID !== 1'h1);
        d = S_AXI_RDATA;
        r = S_AXI_RRESP;
        S_AXI_RREADY <= 1'h0;
    endtask

    initial
    begin
        repeat (4) @(posedge CLOCK);
        RST <= 1'h0;
        foreach (rows[i])
        begin
            wr(rows[i].req);
            `CHK(r, rows[i].resp)
            rd(rows[i].req.addr);
            `CHK(d, rows[i].exp)
            `CHK(r, rows[i].resp)
            $display("row %0d done", i);
        end
        RST <= 1'h1;
        repeat (4) @(posedge CLOCK);
        RST <= 1'h0;
        rd(4'h0);
        `CHK(d, 32'h0)
        rd(4'h4);
        `CHK(d, 32'h0)
        $display("reset test done");
        // preload one tick short of a day
        wr('{4'h0, tdc_pkg::TICKS_PER_DAY - 32'h1, 4'hf});
        wr('{4'h4, 32'h0000_0041, 4'hf});
        rd(4'h0);
        `CHK(d, tdc_pkg::TICKS_PER_DAY - 32'h1)
        while (TICK_PULSE !== 1'h1) @(posedge CLOCK);
        rd(4'h0);
        `CHK(d, 32'h0)
        rd(4'h4);
        `CHK(d, 32'h0000_0042)
        // next tick counts on from zero
        while (TICK_PULSE !== 1'h1) @(posedge CLOCK);
        rd(4'h0);
        `CHK(d, 32'h0000_0001)
        rd(4'h4);
        `CHK(d, 32'h0000_0042)
        $display("wrap test done");
        close_out();
    end
endmodule // tb_tdc_calendar
